// file: rcs_pkg.sv
// Shared constants and carrier types for the clock control/status block.
package rcs_pkg;
    // Register offsets on the indexed register port.
    localparam logic [7:0] OFS_TIMEBASE = 8'h0A;
    localparam logic [7:0] OFS_MODE     = 8'h0B;
    localparam logic [7:0] OFS_FLAGS    = 8'h0C;

    // Field positions in the timebase/rate register.
    localparam int UIP_BIT = 7;
    localparam int TBC_LSB = 4;
    localparam int RS_LSB  = 0;

    // Field positions in the mode register, plus the 32k enable in the flags register.
    localparam int HOLD_BIT  = 7;
    localparam int PIE_BIT   = 6;
    localparam int AIE_BIT   = 5;
    localparam int UIE_BIT   = 4;
    localparam int SQUARE_WAVE_ENABLE_BIT  = 3;
    localparam int DF_BIT    = 2;
    localparam int HF_BIT    = 1;
    localparam int DSE_BIT   = 0;
    localparam int K32E_BIT  = 2;

    // Reset values of the writable registers.
    localparam logic [2:0] TBC_RESET  = 3'h0;
    localparam logic [3:0] RS_RESET   = 4'h0;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // Timebase control patterns.
    localparam logic [2:0] TBC_RUN  = 3'h2;
    localparam logic [2:0] TBC_RUNW = 3'h3;

    // Timing: system clock, doubled timebase, first update delay, lead.
    localparam int CLK_HZ      = 100_000_000;
    localparam int TB_HZ       = 32768;
    localparam int TB_DIV      = CLK_HZ / (2 * TB_HZ);
    localparam int FIRST_MS    = 500;
    localparam int FIRST_TICKS = FIRST_MS * TB_HZ / 1000;
    localparam int UIP_LEAD_US = 244;
    localparam int UIP_LEAD    = (UIP_LEAD_US * TB_HZ + 999999) / 1000000;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rcs_req_t;

    // Calendar hints from the time counters.
    typedef struct packed {
        logic fallDay;
        logic springDay;
        logic at15959;
    } rcs_time_t;

    // Commands and formats toward the time counters.
    typedef struct packed {
        logic xfer;
        logic setBack;
        logic springFwd;
        logic binaryFmt;
        logic hour24;
    } rcs_cmd_t;
endpackage

// file: rcs_control_status_regs.sv
// Control and status registers of the real-time clock.
`timescale 1ns/10ps
// Function
// - Status bit marks each update cycle.
// - Hold bit forces update status low.
// - Pattern 010 runs oscillator and divider.
// - Pattern 11X runs oscillator, divider stopped.
// - First update 500 ms after start.
// - Rate select picks one shared frequency.
// - Hold bit blocks buffer transfers.
// - Hold bit clears update interrupt enable.
// - Periodic enable gates periodic interrupts.
// - Alarm enable gates alarm interrupts.
// - Update enable gates update interrupts.
// - Square-wave enable drives output, else low unless 32k on.
// - Data format bit selects binary or BCD.
// - Hour format bit selects 24 or 12.
// - October fall-back once past 1:59:59.
// - April spring-forward from 2:00 to 3:00.
// - Combined flag on any enabled event.
// - Reading flags clears all flags.
// - Periodic flag set each periodic interval.
// - Alarm flag set on alarm event.
// - Update flag set at update end.
// - Low four flag bits read zero.
// - Pattern 011 adds writable flags, 32k.
// - Other patterns keep oscillator stopped.
module rcs_control_status_regs (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  rcs_pkg::rcs_req_t  busReq,
    output logic [7:0]         rdData_q,
    input  rcs_pkg::rcs_time_t timeIn,
    input  wire logic          alarmEvent,
    output logic               irqOut_q,
    output logic               sqwOut_q,
    output rcs_pkg::rcs_cmd_t  cmd_q
);
    import rcs_pkg::*;

    // Bit index of the divider chain for a rate code.
    function automatic logic [3:0] rateBit(input logic [3:0] rs);
        logic [3:0] idx;
        idx = 4'h0;
        if (rs == 4'h1) begin
            idx = 4'h6;
        end else if (rs == 4'h2) begin
            idx = 4'h7;
        end else if (rs >= 4'h3) begin
            idx = rs - 4'h2;
        end
        return idx;
    endfunction

    localparam logic [10:0] PRE_LAST   = 11'(TB_DIV - 1);
    localparam logic [14:0] CHAIN_LAST = 15'h7FFF;
    localparam logic [14:0] FIRST_LOAD = 15'(32768 - FIRST_TICKS);
    localparam logic [14:0] UIP_POINT  = 15'(32768 - UIP_LEAD);

    logic [2:0]  tbc_q;
    logic [3:0]  rs_q;
    logic [7:0]  mode_q;
    logic [2:0]  evFlags_q;
    logic        k32_q;
    logic [10:0] preCnt_q;
    logic        ph_q;
    logic [14:0] chain_q;
    logic        uip_q;
    logic        rateOld_q;
    logic        fellBack_q;

    // Register port decode.
    wire wrA = busReq.wr && (busReq.addr == OFS_TIMEBASE);
    wire wrB = busReq.wr && (busReq.addr == OFS_MODE);
    wire rdC = busReq.rd && (busReq.addr == OFS_FLAGS);
    wire [2:0] wrTbc = busReq.wdata[TBC_LSB+2:TBC_LSB];

    // Timebase mode decode; any other pattern leaves everything stopped.
    wire oscOn = (tbc_q[2:1] == 2'b01) || (tbc_q[2:1] == 2'b11);
    wire divOn = (tbc_q[2:1] == 2'b01);
    wire flagsWritable = (tbc_q == TBC_RUNW);
    wire wrC = busReq.wr && (busReq.addr == OFS_FLAGS) && flagsWritable;
    wire startDiv = wrA && (wrTbc[2:1] == 2'b01);

    // Timebase ticks at twice and once the 32.768 kHz rate.
    wire tick2 = oscOn && (preCnt_q == PRE_LAST);
    wire tick  = tick2 && ph_q;

    // Update cycle boundaries within each second.
    wire secEnd   = divOn && tick && (chain_q == CHAIN_LAST);
    wire uipStart = divOn && tick && (chain_q == UIP_POINT);
    wire hold     = mode_q[HOLD_BIT];

    // One selected tap feeds both the square wave and the periodic event.
    wire [3:0] tap = rateBit(rs_q);
    wire rateOn  = divOn && (rs_q != 4'h0);
    wire rateLvl = rateOn && chain_q[tap];
    wire pEvent  = rateOn && rateOld_q && !rateLvl;
    wire k32On   = flagsWritable && k32_q;

    // Mode register next value; the hold bit wipes the update enable.
    wire [7:0] modeRaw  = wrB ? busReq.wdata : mode_q;
    wire [7:0] modeNext = {modeRaw[7:5], modeRaw[UIE_BIT] & ~modeRaw[7],
                           modeRaw[3:0]};
    wire [2:0] enNext = {modeNext[PIE_BIT], modeNext[AIE_BIT],
                         modeNext[UIE_BIT]};
    wire [2:0] enQ = {mode_q[PIE_BIT], mode_q[AIE_BIT], mode_q[UIE_BIT]};

    // Event flags: a new event beats a clearing read in the same cycle.
    wire [2:0] ev = {pEvent, alarmEvent, secEnd};
    wire [2:0] flagsBase = wrC ? busReq.wdata[6:4] :
                           (rdC ? 3'h0 : evFlags_q);
    wire [2:0] flagsNext = flagsBase | ev;
    wire       intfHit = |(flagsNext & enNext);
    wire       intfNext = ((rdC || wrC) ? 1'b0 : irqOut_q) ||
                          intfHit;

    // Update status: raised ahead of the cycle, dropped at its end.
    wire uipNext = hold ? 1'b0 :
                   (uipStart ? 1'b1 : (secEnd ? 1'b0 : uip_q));

    // Square-wave output level.
    wire sqwNext = k32On ? ph_q :
                   (mode_q[SQUARE_WAVE_ENABLE_BIT] && rateLvl);

    // Daylight-saving adjustments, issued with the update they replace.
    wire daylight_saving_enable = mode_q[DSE_BIT];
    wire fallNow = secEnd && daylight_saving_enable && timeIn.fallDay && timeIn.at15959 &&
                   !fellBack_q;
    wire springNow = secEnd && daylight_saving_enable && timeIn.springDay &&
                     timeIn.at15959;
    wire fellNext = fallNow || (fellBack_q && timeIn.fallDay);

    // Read multiplexer; the flags view shows values before the clear.
    wire [7:0] regA = {uip_q, tbc_q, rs_q};
    wire [7:0] regC = {irqOut_q, evFlags_q, 4'h0};
    wire [7:0] rdMux = (busReq.addr == OFS_TIMEBASE) ? regA :
                       (busReq.addr == OFS_MODE)     ? mode_q :
                       (busReq.addr == OFS_FLAGS)    ? regC : 8'h00;

    wire [4:0] cmdNext = {secEnd && !hold, fallNow, springNow,
                          mode_q[DF_BIT], mode_q[HF_BIT]};

    // Timebase/rate register; the status bit is not writable.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tbc_q <= TBC_RESET;
            rs_q  <= RS_RESET;
        end else if (wrA) begin
            tbc_q <= wrTbc;
            rs_q  <= busReq.wdata[RS_LSB+3:RS_LSB];
        end
    end

    // Mode register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= modeNext;
        end
    end

    // Event flags, combined flag and 32 kHz enable.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evFlags_q <= 3'h0;
            irqOut_q  <= 1'b0;
            k32_q     <= 1'b0;
        end else begin
            evFlags_q <= flagsNext;
            irqOut_q  <= intfNext;
            if (wrC) begin
                k32_q <= busReq.wdata[K32E_BIT];
            end
        end
    end

    // Prescaler from the system clock down to the doubled timebase.
    // The ratio is rounded down, so the timebase runs slightly fast.
    always_ff @(posedge clk) begin
        if (sys_rst || !oscOn || tick2) begin
            preCnt_q <= 11'h000;
        end else begin
            preCnt_q <= preCnt_q + 11'h001;
        end
    end

    // Phase flop: halves the doubled tick and forms the 32 kHz wave.
    always_ff @(posedge clk) begin
        if (sys_rst || !oscOn) begin
            ph_q <= 1'b0;
        end else if (tick2) begin
            ph_q <= !ph_q;
        end
    end

    // Divider chain; a start preloads it so the first second is half long.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chain_q <= 15'h0000;
        end else if (startDiv) begin
            chain_q <= FIRST_LOAD;
        end else if (!divOn) begin
            chain_q <= 15'h0000;
        end else if (tick) begin
            chain_q <= chain_q + 15'h0001;
        end
    end

    // Update status, tap history and fall-back memory.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            uip_q      <= 1'b0;
            rateOld_q  <= 1'b0;
            fellBack_q <= 1'b0;
        end else begin
            uip_q      <= uipNext;
            rateOld_q  <= rateLvl;
            fellBack_q <= fellNext;
        end
    end

    // Registered outputs: read data, square wave and counter commands.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_q <= 8'h00;
            sqwOut_q <= 1'b0;
            cmd_q    <= '0;
        end else begin
            rdData_q <= busReq.rd ? rdMux : 8'h00;
            sqwOut_q <= sqwNext;
            cmd_q    <= cmdNext;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_UIP_HOLD: assert property (
        $past(hold) |-> !uip_q)
        else $error("Update status set while hold bit is on.");

    AST_UIP_END: assert property (
        secEnd ##1 !sys_rst |-> !uip_q)
        else $error("Update status not cleared at update end.");

    AST_UIE_CLR: assert property (
        mode_q[HOLD_BIT] |-> !mode_q[UIE_BIT])
        else $error("Update enable survives the hold bit.");

    AST_DIV_STOP: assert property (
        (!divOn && !startDiv) [*2] |-> chain_q == 15'h0000)
        else $error("Divider chain moves while disabled.");

    AST_FIRST: assert property (
        startDiv |=> chain_q == FIRST_LOAD)
        else $error("Start did not preload the half-second delay.");

    AST_PF_SET: assert property (
        pEvent |=> evFlags_q[2])
        else $error("Periodic event lost.");

    AST_RD_CLR: assert property (
        rdC && (ev == 3'h0) |=> evFlags_q == 3'h0 && !irqOut_q)
        else $error("Flag read did not clear the flags.");

    AST_IRQ: assert property (
        |(evFlags_q & enQ) |-> irqOut_q)
        else $error("Enabled event without combined flag.");

    AST_SQW_LOW: assert property (
        !mode_q[SQUARE_WAVE_ENABLE_BIT] && !k32On |=> !sqwOut_q)
        else $error("Square wave driven while disabled.");

    AST_RATE_OFF: assert property (
        rs_q == 4'h0 |-> !pEvent)
        else $error("Periodic event with rate code zero.");

    AST_RD_LOW: assert property (
        $past(rdC) |-> rdData_q[3:0] == 4'h0)
        else $error("Unused flag bits read nonzero.");

    AST_XFER: assert property (
        cmd_q.xfer |-> !$past(hold))
        else $error("Transfer issued during hold.");

    COV_UPDATE: cover property (uipStart ##[1:1000] secEnd);
    COV_IRQ_RD: cover property (irqOut_q ##1 rdC ##1 !irqOut_q);
    COV_PERIOD: cover property (pEvent && mode_q[PIE_BIT]);
    COV_FALL:   cover property (fallNow);
endmodule

// file: rcs_control_status_regs_test.sv
// Self-checking testbench of the clock control and status registers.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module rcs_control_status_regs_test;
    import rcs_pkg::*;
    logic       clk        = 1'b0;
    logic       sys_rst    = 1'b1;
    rcs_req_t   busReq     = '0;
    rcs_time_t  timeIn     = '0;
    logic       alarmEvent = 1'b0;
    logic [7:0] rdData_q;
    logic       irqOut_q;
    logic       sqwOut_q;
    rcs_cmd_t   cmd_q;
    logic       rdLate     = 1'b0;
    logic [7:0] expQ[$];
    logic [7:0] expV;
    logic [7:0] v;
    int         failures    = 0;
    int         comparisons = 0;
    int         seed        = 6;
    int         n;

    rcs_control_status_regs dut_u (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .busReq     (busReq),
        .rdData_q   (rdData_q),
        .timeIn     (timeIn),
        .alarmEvent (alarmEvent),
        .irqOut_q   (irqOut_q),
        .sqwOut_q   (sqwOut_q),
        .cmd_q      (cmd_q)
    );

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Read data stand only in the cycle after the strobe, so mark that cycle.
    always @(posedge clk) begin
        rdLate <= busReq.rd;
    end

    // Compare each read answer with the oldest note, away from the edge.
    always @(negedge clk) begin
        if (rdLate) begin
            expV = expQ.pop_front();
            `CHK("rdData_q", expV, rdData_q)
        end
    end

    // One bus cycle; strobes change only just after a rising edge.
    task automatic put(input logic [7:0] a, d, input logic w, r);
        @(posedge clk);
        busReq <= '{a, d, w, r};
    endtask

    task automatic wr(input logic [7:0] a, d);
        put(a, d, 1'b1, 1'b0);
    endtask

    // The note goes in before the strobe so the monitor always finds it.
    task automatic rd(input logic [7:0] a, e);
        expQ.push_back(e);
        put(a, 8'h00, 1'b0, 1'b1);
    endtask

    task automatic idle(input int c);
        repeat (c) put(8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    // One-cycle alarm pulse, then wait until the interrupt can have landed.
    task automatic alarm();
        @(posedge clk);
        alarmEvent <= 1'b1;
        @(posedge clk);
        alarmEvent <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well beyond the longest wait in the sequence.
    initial begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFS_TIMEBASE, 8'h00);
        rd(OFS_MODE, 8'h00);
        rd(OFS_FLAGS, 8'h00);
        wr(8'h0F, 8'hFF);
        rd(8'h0F, 8'h00);
        // Random mode values; the oscillator is off, so no event can fire.
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(OFS_MODE, v);
            rd(OFS_MODE, v[7] ? (v & 8'hEF) : v);
            idle(1);
            @(negedge clk);
            `CHK("binaryFmt", v[2], cmd_q.binaryFmt)
            `CHK("hour24", v[1], cmd_q.hour24)
        end
        wr(OFS_MODE, 8'h00);
        wr(OFS_TIMEBASE, 8'hA0);
        rd(OFS_TIMEBASE, 8'h20);
        wr(OFS_FLAGS, 8'h70);
        rd(OFS_FLAGS, 8'h00);
        // Enabled alarm raises the interrupt until the flags are read.
        wr(OFS_MODE, 8'h20);
        idle(1);
        alarm();
        `CHK("irqOut_q", 1'b1, irqOut_q)
        rd(OFS_FLAGS, 8'hA0);
        rd(OFS_FLAGS, 8'h00);
        idle(1);
        @(negedge clk);
        `CHK("irqOut_q", 1'b0, irqOut_q)
        // A masked alarm still sets its flag but not the combined one.
        wr(OFS_MODE, 8'h00);
        idle(1);
        alarm();
        `CHK("irqOut_q", 1'b0, irqOut_q)
        rd(OFS_FLAGS, 8'h20);
        // Pattern 011 lets software load the flags directly.
        wr(OFS_TIMEBASE, 8'h30);
        wr(OFS_FLAGS, 8'h10);
        rd(OFS_FLAGS, 8'h10);
        rd(OFS_FLAGS, 8'h00);
        // Periodic events at 8192 Hz with the periodic enable set.
        wr(OFS_TIMEBASE, 8'h23);
        wr(OFS_MODE, 8'h40);
        idle(1);
        n = 0;
        while (irqOut_q !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        `CHK("irqOut_q", 1'b1, irqOut_q)
        rd(OFS_FLAGS, 8'hC0);
        rd(OFS_FLAGS, 8'h00);
        // Square wave must go high when enabled and stay low when not.
        wr(OFS_MODE, 8'h08);
        idle(1);
        n = 0;
        while (sqwOut_q !== 1'b1 && n < 15000) begin
            @(negedge clk);
            n++;
        end
        `CHK("sqwOut_q", 1'b1, sqwOut_q)
        wr(OFS_MODE, 8'h00);
        idle(2);
        n = 0;
        repeat (13000) begin
            @(negedge clk);
            if (sqwOut_q !== 1'b0) n++;
        end
        `CHK("sqwOut_q high count", 0, n)
        // Hold set: update status reads low and the enable stays cleared.
        wr(OFS_MODE, 8'h90);
        rd(OFS_TIMEBASE, 8'h23);
        rd(OFS_MODE, 8'h80);
        idle(2);
        repeat (3) @(negedge clk);
        tally_and_finish();
    end
endmodule
